// ---- dtcc_defines.svh ----
`ifndef DTCC_DEFINES_SVH
`define DTCC_DEFINES_SVH
// ----------------------------------------
// field widths and reset values
// ----------------------------------------
`define DTCC_DATA_W        12
`define DTCC_CLOCK_DIVIDER_VALUE_W       7
`define DTCC_CLOCK_DIVIDER_VALUE_RST     7'h00
`define DTCC_REFRESH_W     6
`define DTCC_HOLD_W        10
`define DTCC_WARM_W        14
`define DTCC_EVSEL_W       4
// ----------------------------------------
// timing figures (ns) and clock rate
// ----------------------------------------
`define DTCC_CLK_PERIOD_NS 8
`define DTCC_WARM_L0_NS    100000
`define DTCC_WARM_L1_NS    85000
`define DTCC_WARM_L23_NS   8000
`define DTCC_WARM_L0_CYC   ((`DTCC_WARM_L0_NS + `DTCC_CLK_PERIOD_NS - 1) / `DTCC_CLK_PERIOD_NS)
`define DTCC_WARM_L1_CYC   ((`DTCC_WARM_L1_NS + `DTCC_CLK_PERIOD_NS - 1) / `DTCC_CLK_PERIOD_NS)
`define DTCC_WARM_L23_CYC  ((`DTCC_WARM_L23_NS + `DTCC_CLK_PERIOD_NS - 1) / `DTCC_CLK_PERIOD_NS)
`endif

// ---- dtcc_pkg.sv ----
`default_nettype none
package dtcc_pkg;
  // trigger selection codes
  typedef enum logic [2:0] {
    DTCC_TRIG_SW      = 3'h0,
    DTCC_TRIG_EVENT   = 3'h1,
    DTCC_TRIG_REFRESH = 3'h2,
    DTCC_TRIG_SW_EV   = 3'h3,
    DTCC_TRIG_SW_REF  = 3'h4,
    DTCC_TRIG_SENSE   = 3'h5
  } dtcc_trig_t;
  // channel state
  typedef enum logic [1:0] {
    DTCC_CH_IDLE,
    DTCC_CH_WARM,
    DTCC_CH_DRIVE,
    DTCC_CH_HOLD
  } dtcc_ch_t;
endpackage
`default_nettype wire

// ---- dtcc_prescaler.sv ----
`include "dtcc_defines.svh"
`default_nettype none
// converter clock divider: one tick every divider+1 input ticks
module dtcc_prescaler #(
  parameter int CLOCK_DIVIDER_VALUE_W = `DTCC_CLOCK_DIVIDER_VALUE_W
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               srst,
  // control
  input  wire logic               run,
  input  wire logic               inTick,
  input  wire logic               restart,
  input  wire logic [CLOCK_DIVIDER_VALUE_W-1:0] divider,
  // converter tick
  output var  logic               convTick
);
  logic [CLOCK_DIVIDER_VALUE_W-1:0] cnt_r, cnt_nxt;
  logic               tick_r, tick_nxt;

  // ----------------------------------------
  // divide
  // ----------------------------------------
  // count input ticks, restart clears phase
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!run || restart) begin
      cnt_nxt = '0;
    end else if (inTick) begin
      if (cnt_r >= divider) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign convTick = tick_r;
endmodule // dtcc_prescaler
`default_nettype wire

// ---- dtcc_refresh_timer.sv ----
`include "dtcc_defines.svh"
`default_nettype none
// refresh timer: wraps after interval converter ticks
module dtcc_refresh_timer #(
  parameter int REF_W = `DTCC_REFRESH_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // control
  input  wire logic             run,
  input  wire logic             convTick,
  input  wire logic [REF_W-1:0] interval,
  // wrap pulse
  output var  logic             wrap
);
  logic [REF_W-1:0] cnt_r, cnt_nxt;
  logic             wrap_r, wrap_nxt;

  // ----------------------------------------
  // count
  // ----------------------------------------
  // count converter ticks, wrap at interval
  always_comb begin
    cnt_nxt  = cnt_r;
    wrap_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (convTick) begin
      if (cnt_r + 1'b1 >= interval) begin
        cnt_nxt  = '0;
        wrap_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r  <= '0;
      wrap_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      wrap_r <= wrap_nxt;
    end
  end
  assign wrap = wrap_r;
endmodule // dtcc_refresh_timer
`default_nettype wire

// ---- dtcc_top.sv ----
// Function
// - Convert only on enabled channels; event, refresh and sense triggers on disabled channels are ignored.
// - Software modes: a channel data write starts a conversion.
// - Joint write loads both channels and triggers every enabled channel in a software mode.
// - Event modes: pulse on selected event line starts a conversion.
// - Refresh modes: each refresh timer wrap starts a conversion.
// - Sense mode: each sequencer request starts a conversion.
// - Trigger rate at most 0.5 MHz and clock/12; no rate check, a trigger while one is pending merges into it.
// - First conversion after enable runs the programmed warmup.
// - Warm flag set once a channel's warmup completes.
// - Sample mode drives for hold time; continuous drives until disable.
// - Single-ended: channel n drives output n, unsigned 12-bit code.
// - Differential: channel 0 signed code; positive on output 1, negative on 0.
// - Async source uses oscillator; deep sleep while enabled and sync flags error.
// - Differential mode keeps both channels in lock step.
// - Refresh timer runs while an enabled channel picks refresh; wraps and triggers.
// - Prescaler divides by 1 to 128; converter clock should be at most 1 MHz but is not limited, divider 0 ticks on every input tick.
// - Prescaler runs while a channel is enabled; latency varies one period.
// - Divider reset bit restarts the prescaler on each channel 0 trigger.
// - Disabling a channel discards its pending triggers.
// - Data written before enable in software modes converts on enable.
// - Hold time zero in sample mode never drives the output.
`include "dtcc_defines.svh"
`default_nettype none
module dtcc_top #(
  parameter int DATA_W  = `DTCC_DATA_W,
  parameter int CLOCK_DIVIDER_VALUE_W = `DTCC_CLOCK_DIVIDER_VALUE_W,
  parameter int REF_W   = `DTCC_REFRESH_W,
  parameter int HOLD_W  = `DTCC_HOLD_W,
  parameter int WARM_W  = `DTCC_WARM_W,
  parameter int EVSEL_W = `DTCC_EVSEL_W,
  parameter int NEV     = 16
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  // channel enable
  input  wire logic [1:0]           channelEnable,
  // per channel configuration
  input  var  dtcc_pkg::dtcc_trig_t trigSel0,
  input  var  dtcc_pkg::dtcc_trig_t trigSel1,
  input  wire logic [EVSEL_W-1:0]   trigChannelSelect0,
  input  wire logic [EVSEL_W-1:0]   trigChannelSelect1,
  input  wire logic [1:0]           asyncProducerFlag,
  input  wire logic [1:0]           sampleThenRelease,
  input  wire logic [HOLD_W-1:0]    driveHoldTime,
  input  wire logic [WARM_W-1:0]    warmupDuration,
  // shared configuration
  input  wire logic                 differentialEnable,
  input  wire logic                 converterClockSource,
  input  wire logic                 ch0DividerResetOnTrigger,
  input  wire logic [CLOCK_DIVIDER_VALUE_W-1:0]   clockDividerValue,
  input  wire logic [REF_W-1:0]     refreshInterval,
  // data writes
  input  wire logic                 sampleWrite0,
  input  wire logic                 sampleWrite1,
  input  wire logic                 jointWrite,
  input  wire logic [DATA_W-1:0]    sampleData0,
  input  wire logic [DATA_W-1:0]    sampleData1,
  // trigger sources
  input  wire logic [NEV-1:0]       reflexEvent,
  input  wire logic [1:0]           senseRequest,
  input  wire logic                 oscTick,
  input  wire logic                 deepSleepEnter,
  // status
  output var  logic [1:0]           channelActiveFlag,
  output var  logic [1:0]           channelWarmFlag,
  output var  logic                 deepSleepErrorFlag,
  // analog stage drive
  output var  logic [1:0]           outDriveEn,
  output var  logic [DATA_W-1:0]    outCode0,
  output var  logic [DATA_W-1:0]    outCode1
);
  import dtcc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic isSw(input dtcc_trig_t t);
    return t == DTCC_TRIG_SW || t == DTCC_TRIG_SW_EV || t == DTCC_TRIG_SW_REF;
  endfunction
  function automatic logic isEv(input dtcc_trig_t t);
    return t == DTCC_TRIG_EVENT || t == DTCC_TRIG_SW_EV;
  endfunction
  function automatic logic isRef(input dtcc_trig_t t);
    return t == DTCC_TRIG_REFRESH || t == DTCC_TRIG_SW_REF;
  endfunction

  dtcc_trig_t         trigSel [2];
  logic [EVSEL_W-1:0] evSel [2];
  logic [1:0]         swWrite;
  logic               convTick, refreshWrap, inTick, prescRun, ch0Trig;
  logic [1:0]         evHit, trigNow;
  logic [NEV-1:0]     evPrev_r;

  assign trigSel[0] = trigSel0;
  assign trigSel[1] = trigSel1;
  assign evSel[0]   = trigChannelSelect0;
  assign evSel[1]   = trigChannelSelect1;
  assign swWrite    = {sampleWrite1 | jointWrite, sampleWrite0 | jointWrite};
  // input tick: every clk in sync mode, oscillator ticks in async mode
  assign inTick     = converterClockSource ? oscTick : 1'b1;
  assign prescRun   = |channelEnable;

  // ----------------------------------------
  // clock division and refresh
  // ----------------------------------------
  dtcc_prescaler #(.CLOCK_DIVIDER_VALUE_W(CLOCK_DIVIDER_VALUE_W)) dtcc_prescaler_inst (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .run      (prescRun),
    .inTick   (inTick),
    .restart  (ch0Trig & ch0DividerResetOnTrigger),
    .divider  (clockDividerValue),
    .convTick (convTick)
  );

  dtcc_refresh_timer #(.REF_W(REF_W)) dtcc_refresh_timer_inst (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .run      ((channelEnable[0] & isRef(trigSel[0])) |
               (channelEnable[1] & isRef(trigSel[1]))),
    .convTick (convTick),
    .interval (refreshInterval),
    .wrap     (refreshWrap)
  );

  // ----------------------------------------
  // trigger decode
  // ----------------------------------------
  // rising edge on the selected event line
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      evHit[i] = reflexEvent[evSel[i]] & ~evPrev_r[evSel[i]];
      trigNow[i] = (isSw(trigSel[i]) & swWrite[i])
                 | (isEv(trigSel[i]) & evHit[i])
                 | (isRef(trigSel[i]) & refreshWrap)
                 | ((trigSel[i] == DTCC_TRIG_SENSE) & senseRequest[i]);
    end
    // differential: channel 1 follows channel 0 in lock step
    if (differentialEnable) begin
      trigNow[1] = trigNow[0];
    end
  end
  assign ch0Trig = trigNow[0] & channelEnable[0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      evPrev_r <= '0;
    end else begin
      evPrev_r <= reflexEvent;
    end
  end

  // ----------------------------------------
  // channel engines
  // ----------------------------------------
  dtcc_ch_t          st_r [2], st_nxt [2];
  logic [1:0]        pend_r, pend_nxt, dataNew_r, dataNew_nxt;
  logic [1:0]        warm_r, warm_nxt, drive_r, drive_nxt, en_r;
  logic [WARM_W-1:0] wcnt_r [2], wcnt_nxt [2];
  logic [HOLD_W-1:0] hcnt_r [2], hcnt_nxt [2];
  logic [DATA_W-1:0] data_r [2], data_nxt [2];
  logic [DATA_W-1:0] live_r [2], live_nxt [2];

  // pending trigger, warmup, then drive per the drive style
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      st_nxt[i]      = st_r[i];
      pend_nxt[i]    = pend_r[i];
      dataNew_nxt[i] = dataNew_r[i];
      warm_nxt[i]    = warm_r[i];
      drive_nxt[i]   = drive_r[i];
      wcnt_nxt[i]    = wcnt_r[i];
      hcnt_nxt[i]    = hcnt_r[i];
      live_nxt[i]    = live_r[i];
      data_nxt[i]    = data_r[i];
      if (swWrite[i]) begin
        data_nxt[i]    = (i == 0) ? sampleData0 : sampleData1;
        dataNew_nxt[i] = 1'b1;
      end
      if (!channelEnable[i]) begin
        st_nxt[i]    = DTCC_CH_IDLE;
        pend_nxt[i]  = 1'b0;
        warm_nxt[i]  = 1'b0;
        drive_nxt[i] = 1'b0;
        wcnt_nxt[i]  = '0;
      end else begin
        if (trigNow[i] || (!en_r[i] && isSw(trigSel[i]) && dataNew_r[i])) begin
          pend_nxt[i] = 1'b1;
        end
        case (st_r[i])
          DTCC_CH_IDLE: begin
            if (pend_r[i] && convTick) begin
              pend_nxt[i]    = trigNow[i]; // same-tick trigger stays pending
              live_nxt[i]    = data_r[i];
              dataNew_nxt[i] = swWrite[i];
              st_nxt[i]      = warm_r[i] ? DTCC_CH_DRIVE : DTCC_CH_WARM;
            end
          end
          DTCC_CH_WARM: begin
            if (wcnt_r[i] >= warmupDuration) begin
              warm_nxt[i] = 1'b1;
              st_nxt[i]   = DTCC_CH_DRIVE;
            end else begin
              wcnt_nxt[i] = wcnt_r[i] + 1'b1;
            end
          end
          DTCC_CH_DRIVE: begin
            hcnt_nxt[i] = '0;
            if (!sampleThenRelease[i]) begin
              drive_nxt[i] = 1'b1;
              st_nxt[i]    = DTCC_CH_IDLE;
            end else if (driveHoldTime == '0) begin
              drive_nxt[i] = 1'b0;
              st_nxt[i]    = DTCC_CH_IDLE;
            end else begin
              drive_nxt[i] = 1'b1;
              st_nxt[i]    = DTCC_CH_HOLD;
            end
          end
          DTCC_CH_HOLD: begin
            if (convTick) begin
              if (hcnt_r[i] + 1'b1 >= driveHoldTime) begin
                drive_nxt[i] = 1'b0;
                st_nxt[i]    = DTCC_CH_IDLE;
              end else begin
                hcnt_nxt[i] = hcnt_r[i] + 1'b1;
              end
            end
          end
          default: st_nxt[i] = DTCC_CH_IDLE;
        endcase
      end
    end
  end

  // channel registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < 2; i++) begin
        st_r[i]   <= DTCC_CH_IDLE;
        wcnt_r[i] <= '0;
        hcnt_r[i] <= '0;
        data_r[i] <= '0;
        live_r[i] <= '0;
      end
      pend_r    <= 2'h0;
      dataNew_r <= 2'h0;
      warm_r    <= 2'h0;
      drive_r   <= 2'h0;
      en_r      <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        st_r[i]   <= st_nxt[i];
        wcnt_r[i] <= wcnt_nxt[i];
        hcnt_r[i] <= hcnt_nxt[i];
        data_r[i] <= data_nxt[i];
        live_r[i] <= live_nxt[i];
      end
      pend_r    <= pend_nxt;
      dataNew_r <= dataNew_nxt;
      warm_r    <= warm_nxt;
      drive_r   <= drive_nxt;
      en_r      <= channelEnable;
    end
  end

  // ----------------------------------------
  // outputs and status
  // ----------------------------------------
  logic [1:0]        actNxt, drvNxt;
  logic [DATA_W-1:0] code0Nxt, code1Nxt;
  logic              errNxt;

  // output mapping and deep sleep check
  always_comb begin
    actNxt = channelEnable | drive_r;
    drvNxt = drive_r;
    if (differentialEnable) begin
      // signed code: flip sign to offset form, negative side inverted
      code1Nxt = {~live_r[0][DATA_W-1], live_r[0][DATA_W-2:0]};
      code0Nxt = ~code1Nxt;
      drvNxt   = {drive_r[0], drive_r[0]};
    end else begin
      code0Nxt = live_r[0];
      code1Nxt = live_r[1];
    end
    errNxt = deepSleepErrorFlag |
             (deepSleepEnter & (|channelEnable) & ~converterClockSource);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      channelActiveFlag  <= 2'h0;
      channelWarmFlag    <= 2'h0;
      deepSleepErrorFlag <= 1'b0;
      outDriveEn         <= 2'h0;
      outCode0           <= '0;
      outCode1           <= '0;
    end else begin
      channelActiveFlag  <= actNxt;
      channelWarmFlag    <= warm_r;
      deepSleepErrorFlag <= errNxt;
      outDriveEn         <= drvNxt;
      outCode0           <= code0Nxt;
      outCode1           <= code1Nxt;
    end
  end
endmodule // dtcc_top
`default_nettype wire

// ---- dtcc_properties.sv ----
`default_nettype none
// --------------
// port checker
// --------------
module dtcc_properties #(
  parameter int HOLD_W  = 10,
  parameter int CLOCK_DIVIDER_VALUE_W = 7,
  parameter int DATA_W  = 12
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               srst,
  // configuration
  input wire logic [1:0]         channelEnable,
  input wire logic [1:0]         sampleThenRelease,
  input wire logic [HOLD_W-1:0]  driveHoldTime,
  input wire logic               differentialEnable,
  input wire logic               converterClockSource,
  input wire logic [CLOCK_DIVIDER_VALUE_W-1:0] clockDividerValue,
  input wire logic               deepSleepEnter,
  // status and drive
  input wire logic [1:0]         channelActiveFlag,
  input wire logic [1:0]         channelWarmFlag,
  input wire logic               deepSleepErrorFlag,
  input wire logic [1:0]         outDriveEn,
  input wire logic [DATA_W-1:0]  outCode0,
  input wire logic [DATA_W-1:0]  outCode1
);
  logic [15:0] driveLen_r, driveLen_nxt;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // length of the running channel 0 drive
  always_comb begin
    driveLen_nxt = outDriveEn[0] ? driveLen_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_sys) begin
    driveLen_r <= srst ? 16'h0000 : driveLen_nxt;
  end
  // entry into deep sleep on the peripheral clock
  sequence sleepEntry_s;
    deepSleepEnter && (channelEnable != 2'h0) && !converterClockSource;
  endsequence
  sequence errorShown_s;
    ##[1:3] deepSleepErrorFlag;
  endsequence
  idle_no_drive_a: assert property ((outDriveEn & ~channelActiveFlag) == 2'h0)
    else $error("output driven on an inactive channel");
  drive_after_warm_a: assert property (outDriveEn[0] |-> channelWarmFlag[0])
    else $error("channel 0 driven before warmup done");
  warm_clear_a: assert property ($fell(channelEnable[0]) |-> ##[1:4] !channelWarmFlag[0])
    else $error("warm flag kept after disable");
  hold_bound_a: assert property (sampleThenRelease[0] && outDriveEn[0] |->
    int'(driveLen_r) <= int'(driveHoldTime) * (int'(clockDividerValue) + 1) + 2)
    else $error("sample drive longer than hold time");
  zero_hold_a: assert property (sampleThenRelease[0] && driveHoldTime == '0 |-> !outDriveEn[0])
    else $error("zero hold time still drives");
  differential_enable_inverse_a: assert property (differentialEnable && outDriveEn[1] |-> outCode0 == ~outCode1)
    else $error("differential outputs not complementary");
  differential_enable_lockstep_a: assert property (differentialEnable && channelEnable == 2'h3 |->
    outDriveEn[0] == outDriveEn[1])
    else $error("differential channels out of step");
  sleep_error_set_a: assert property (sleepEntry_s |-> errorShown_s)
    else $error("deep sleep error not raised");
  sleep_error_sticky_a: assert property (deepSleepErrorFlag |=> deepSleepErrorFlag)
    else $error("deep sleep error dropped");
  sleep_error_cause_a: assert property ($rose(deepSleepErrorFlag) |->
    $past(deepSleepEnter) || $past(deepSleepEnter, 2))
    else $error("deep sleep error without sleep entry");
endmodule // dtcc_properties

bind dtcc_top dtcc_properties #(.HOLD_W(HOLD_W), .CLOCK_DIVIDER_VALUE_W(CLOCK_DIVIDER_VALUE_W), .DATA_W(DATA_W))
  dtcc_properties_inst (
  .clk_sys(clk_sys), .srst(srst), .channelEnable(channelEnable),
  .sampleThenRelease(sampleThenRelease), .driveHoldTime(driveHoldTime),
  .differentialEnable(differentialEnable), .converterClockSource(converterClockSource),
  .clockDividerValue(clockDividerValue), .deepSleepEnter(deepSleepEnter),
  .channelActiveFlag(channelActiveFlag), .channelWarmFlag(channelWarmFlag),
  .deepSleepErrorFlag(deepSleepErrorFlag), .outDriveEn(outDriveEn),
  .outCode0(outCode0), .outCode1(outCode1)
);
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dtcc_pkg::*;
  // --------------
  // signals
  // --------------
  logic        clk_sys, srst, differentialEnable, converterClockSource, ch0DividerResetOnTrigger;
  logic        sampleWrite0, sampleWrite1, jointWrite, oscTick, deepSleepEnter, deepSleepErrorFlag;
  logic [1:0]  channelEnable, asyncProducerFlag, sampleThenRelease, senseRequest;
  logic [1:0]  channelActiveFlag, channelWarmFlag, outDriveEn;
  dtcc_trig_t  trigSel0, trigSel1;
  logic [3:0]  trigChannelSelect0, trigChannelSelect1;
  logic [9:0]  driveHoldTime;
  logic [13:0] warmupDuration;
  logic [6:0]  clockDividerValue;
  logic [5:0]  refreshInterval;
  logic [11:0] sampleData0, sampleData1, outCode0, outCode1;
  logic [15:0] reflexEvent;
  int          failCount = 0, nCompared = 0, oscCnt = 0;

  dtcc_top dtcc_top_inst (
    .clk_sys(clk_sys), .srst(srst), .channelEnable(channelEnable), .trigSel0(trigSel0),
    .trigSel1(trigSel1), .trigChannelSelect0(trigChannelSelect0),
    .trigChannelSelect1(trigChannelSelect1), .asyncProducerFlag(asyncProducerFlag),
    .sampleThenRelease(sampleThenRelease), .driveHoldTime(driveHoldTime),
    .warmupDuration(warmupDuration), .differentialEnable(differentialEnable),
    .converterClockSource(converterClockSource),
    .ch0DividerResetOnTrigger(ch0DividerResetOnTrigger), .clockDividerValue(clockDividerValue),
    .refreshInterval(refreshInterval), .sampleWrite0(sampleWrite0), .sampleWrite1(sampleWrite1),
    .jointWrite(jointWrite), .sampleData0(sampleData0), .sampleData1(sampleData1),
    .reflexEvent(reflexEvent), .senseRequest(senseRequest), .oscTick(oscTick),
    .deepSleepEnter(deepSleepEnter), .channelActiveFlag(channelActiveFlag),
    .channelWarmFlag(channelWarmFlag), .deepSleepErrorFlag(deepSleepErrorFlag),
    .outDriveEn(outDriveEn), .outCode0(outCode0), .outCode1(outCode1)
  );
  // --------------
  // clocks and tasks
  // --------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // oscillator tick, one in twelve cycles
  always @(posedge clk_sys) begin
    oscCnt <= (oscCnt == 11) ? 0 : oscCnt + 1;
    oscTick <= (oscCnt == 0);
  end
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic doReset();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
  endtask
  // disable both channels and let drives finish
  task automatic idle();
    @(posedge clk_sys);
    channelEnable <= 2'h0;
    repeat (30) @(posedge clk_sys);
  endtask
  task automatic arm(input logic [1:0] en);
    @(posedge clk_sys);
    channelEnable <= en;
  endtask
  // one-cycle trigger: write, event, sense, wrong event line, write 1, joint write
  task automatic fire(input int k, input logic [11:0] d0, input logic [11:0] d1);
    @(posedge clk_sys);
    sampleData0 <= d0;
    sampleData1 <= d1;
    case (k)
      0: sampleWrite0 <= 1'b1;
      1: reflexEvent[trigChannelSelect0] <= 1'b1;
      2: senseRequest[0] <= 1'b1;
      3: reflexEvent[trigChannelSelect0 + 4'h1] <= 1'b1;
      4: sampleWrite1 <= 1'b1;
      default: jointWrite <= 1'b1;
    endcase
    @(posedge clk_sys);
    {sampleWrite0, sampleWrite1, jointWrite, senseRequest} <= 5'h00;
    reflexEvent <= 16'h0000;
  endtask
  // watch one channel's drive: cycles before it, cycles of it, codes at its start
  task automatic watch(input int ch, input int win, output logic seen, output int lat, len,
                       output logic [11:0] c0, c1);
    seen = 1'b0;
    lat = 0;
    len = 0;
    repeat (win) begin
      @(posedge clk_sys);
      #1;
      if (outDriveEn[ch] === 1'b1) begin
        if (!seen) {c0, c1} = {outCode0, outCode1};
        seen = 1'b1;
        len++;
      end else if (!seen) lat++;
    end
  endtask
  function automatic logic [3:0] accepts(input int m);
    case (m)
      0: return 4'h1;
      1: return 4'h2;
      3: return 4'h3;
      5: return 4'h4;
      default: return 4'hf;
    endcase
  endfunction
  initial begin
    repeat (60000) @(posedge clk_sys);
    failCount++;
    endOfTest();
  end
  // --------------
  // tests
  // --------------
  initial begin
    logic seen;
    int lat, len;
    logic [11:0] c0, c1;
    srst <= 1'b1;
    {differentialEnable, converterClockSource, ch0DividerResetOnTrigger} <= 3'h0;
    {sampleWrite0, sampleWrite1, jointWrite, deepSleepEnter} <= 4'h0;
    {channelEnable, asyncProducerFlag, senseRequest} <= 6'h00;
    trigSel0 <= DTCC_TRIG_SW;
    trigSel1 <= DTCC_TRIG_SW;
    {trigChannelSelect0, trigChannelSelect1} <= 8'h50;
    {sampleData0, sampleData1, reflexEvent} <= 40'h0;
    {sampleThenRelease, driveHoldTime, warmupDuration} <= {2'h3, 10'h004, 14'h0014};
    {clockDividerValue, refreshInterval} <= {7'h00, 6'h10};
    doReset();
    #1;
    check("reset", 12'({channelActiveFlag, channelWarmFlag, outDriveEn}), 12'h000);
    fire(4, 12'h000, 12'h5a5);
    watch(1, 60, seen, lat, len, c0, c1);
    check("disabled ch1", 12'(seen), 12'h000);
    arm(2'h2);
    watch(1, 120, seen, lat, len, c0, c1);
    check("enable ch1", 12'(seen), 12'h001);
    check("code ch1", c1, 12'h5a5);
    $display("test enable done");
    idle();
    {sampleThenRelease, warmupDuration, clockDividerValue} <= {2'h0, 14'h0028, 7'h03};
    ch0DividerResetOnTrigger <= 1'b1;
    arm(2'h1);
    fire(0, 12'habc, 12'h000);
    watch(0, 300, seen, lat, len, c0, c1);
    check("sw write", 12'(seen), 12'h001);
    check("warmup wait", 12'(lat >= 38), 12'h001);
    check("code ch0", c0, 12'habc);
    check("continuous", 12'(len > 200), 12'h001);
    check("warm flag", 12'(channelWarmFlag[0]), 12'h001);
    idle();
    #1;
    check("off state", 12'({channelActiveFlag, outDriveEn, channelWarmFlag}), 12'h000);
    $display("test continuous done");
    {sampleThenRelease, driveHoldTime, warmupDuration} <= {2'h3, 10'h005, 14'h0014};
    {clockDividerValue, ch0DividerResetOnTrigger} <= 8'h00;
    arm(2'h3);
    fire(5, 12'h123, 12'h456);
    watch(0, 100, seen, lat, len, c0, c1);
    check("joint ch0", c0, 12'h123);
    check("hold length", 12'(len >= 4 && len <= 6), 12'h001);
    fire(5, 12'h321, 12'h654);
    watch(1, 100, seen, lat, len, c0, c1);
    check("joint ch1", c1, 12'h654);
    idle();
    clockDividerValue <= 7'h7f;
    arm(2'h1);
    fire(0, 12'h111, 12'h000);
    idle();
    trigSel0 <= DTCC_TRIG_EVENT;
    arm(2'h1);
    watch(0, 400, seen, lat, len, c0, c1);
    check("flushed", 12'(seen), 12'h000);
    $display("test joint done");
    {clockDividerValue, driveHoldTime} <= {7'h00, 10'h002};
    for (int m = 0; m < 6; m++) begin
      idle();
      trigSel0 <= dtcc_trig_t'(3'(m));
      arm(2'h1);
      if (accepts(m) == 4'hf) begin
        watch(0, 150, seen, lat, len, c0, c1);
        check("refresh", 12'(seen), 12'h001);
      end else begin
        for (int k = 0; k < 4; k++) begin
          fire(k, 12'h3c3, 12'h000);
          watch(0, 120, seen, lat, len, c0, c1);
          check("mode", 12'(seen), 12'(accepts(m) >> k) & 12'h001);
        end
      end
    end
    idle();
    trigSel0 <= DTCC_TRIG_SW;
    driveHoldTime <= 10'h000;
    arm(2'h1);
    fire(0, 12'h222, 12'h000);
    watch(0, 150, seen, lat, len, c0, c1);
    check("zero hold", 12'(seen), 12'h000);
    $display("test modes done");
    idle();
    {differentialEnable, driveHoldTime} <= {1'b1, 10'h003};
    arm(2'h3);
    fire(0, 12'h7ff, 12'h000);
    watch(1, 150, seen, lat, len, c0, c1);
    check("differential_enable pos", {c1, c0} == 24'hfff000 ? 12'h001 : 12'h000, 12'h001);
    fire(0, 12'h800, 12'h000);
    watch(1, 100, seen, lat, len, c0, c1);
    check("differential_enable neg", {c1, c0} == 24'h000fff ? 12'h001 : 12'h000, 12'h001);
    idle();
    {differentialEnable, converterClockSource, clockDividerValue} <= {2'h1, 7'h0b};
    arm(2'h1);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      deepSleepEnter <= 1'b1;
      @(posedge clk_sys);
      deepSleepEnter <= 1'b0;
      repeat (5) @(posedge clk_sys);
      #1;
      check("sleep error", 12'(deepSleepErrorFlag), 12'(s));
      converterClockSource <= 1'b0;
    end
    doReset();
    #1;
    check("error after reset", 12'(deepSleepErrorFlag), 12'h000);
    $display("test sleep done");
    endOfTest();
  end
endmodule // tb_top
`default_nettype wire
